// file: logic/bfrs_sequencer.sv
// Fault handling, restart sequencing and phase timing core of the ballast controller
// Functional notes
// RULE1: Filament sense above upper threshold for 700 us stops inverter and PFC.
// RULE2: Each filament fault increments counter; after 200 ms choose action from count.
// RULE3: Counter above 2 requires lamp removal for 100 ms before restart.
// RULE4: Return to valid range without 100 ms removal refuses start.
// RULE5: Outside controller holds off level at least 400 ms.
// RULE6: Startup begins 100 ms after filament detection level is reached.
// RULE7: Any restarting protection fault waits at least first restart period.
// RULE8: Lamp-voltage sense serves filament detection before start, end-of-life in run.
// RULE9: Grounded lamp-voltage sense disables those; 1 us at enable level re-enables.
// RULE10: Deadtime needs negative current crossing for minimum time each period.
// RULE11: No positive current crossing in a run period flags capacitive load.
// RULE12: Shoot-through on low-side current sense shuts down and restarts.
// RULE13: Undervoltage lockout clears test-mode acceleration.
// RULE14: Test mode: preheat four times faster, ignition timeout two times faster.
// RULE15: Test mode: pre-run phase fifteen times faster.
// RULE16: Ignition lasts at least 42 ms, never accelerated.
// RULE17: AC end-of-life check takes 620 us, never accelerated.
// RULE18: Test mode: DC end-of-life time accelerated by 62.
// RULE19: AC check uses peak-to-peak voltage, DC check uses DC offset.
// RULE20: Off time within first restart period skips preheat, longer preheats.
// RULE21: Undervoltage lockout resets fault counter and all timers.
// RULE22: Counter clears after 40 s without a further counted fault.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bfrs_sequencer
    import bfrs_pkg::*;
#(
    parameter int unsigned FIL_FAULT_T    = FIL_FAULT_TICKS,
    parameter int unsigned FAULT_DELAY_T  = FAULT_DELAY_TICKS,
    parameter int unsigned REMOVAL_T      = REMOVAL_TICKS,
    parameter int unsigned START_DELAY_T  = START_DELAY_TICKS,
    parameter int unsigned COUNT_WINDOW_T = COUNT_WINDOW_TICKS,
    parameter int unsigned IGN_MIN_T      = IGN_MIN_TICKS,
    parameter int unsigned EOL_AC_T       = EOL_AC_TICKS,
    parameter int unsigned EOL_DC_T       = EOL_DC_TICKS,
    parameter int unsigned FIRST_RESTART_T = FIRST_RESTART_TICKS,
    parameter int unsigned PREHEAT_T      = PREHEAT_TICKS,
    parameter int unsigned IGN_TIMEOUT_T  = IGN_TIMEOUT_TICKS,
    parameter int unsigned PRE_RUN_T      = PRE_RUN_TICKS,
    parameter int unsigned TICK_CYCLES    = US_CYCLES
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 uvlo,
    input  wire bfrs_pkg::bfrs_sense_t sense,
    output var  bfrs_pkg::bfrs_drive_t drive,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr
);
    import bfrs_pkg::*;

    function automatic logic [31:0] bump(input logic [31:0] cnt, input logic [6:0] step);
        bump = (cnt > 32'hFFFF_FF00) ? cnt : cnt + {25'h0, step};
    endfunction

    logic                core_rst;
    bfrs_state_t         state_reg;
    logic [5:0]          tick_cnt_reg;
    logic                tick;
    logic [31:0]         ph_cnt_reg;
    logic [31:0]         fil_cnt_reg;
    logic [31:0]         rem_cnt_reg;
    logic [31:0]         win_cnt_reg;
    logic [31:0]         off_cnt_reg;
    logic [31:0]         eol_ac_cnt_reg;
    logic [31:0]         eol_dc_cnt_reg;
    logic [5:0]          lvs_cnt_reg;
    logic [7:0]          dt_cnt_reg;
    logic [2:0]          fault_cnt_reg;
    logic                test_reg;
    logic                lvs_en_reg;
    logic                removed_reg;
    logic                pos_seen_reg;
    logic                dt_seen_reg;
    logic                dt_ok_reg;
    logic [5:0]          flags_reg;
    logic [6:0]          ph_step;
    logic                active;
    logic                fil_fault;
    logic                shoot;
    logic                eol_ac_fault;
    logic                eol_dc_fault;
    logic                cap_load;
    logic                dt_miss;
    logic                any_fault;
    logic                ph_done;
    logic                ign_fail;
    logic                wr_access;
    logic                rd_setup;

    // Lockout acts as a full reset of sequencing state and of test acceleration
    assign core_rst = sys_rst | uvlo; // [RULE13] [RULE21]
    assign active = (state_reg == ST_PREHEAT) || (state_reg == ST_IGNITE) ||
                    (state_reg == ST_PRE_RUN) || (state_reg == ST_RUN);
    assign tick = (tick_cnt_reg == 6'(TICK_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (core_rst || tick) begin
            tick_cnt_reg <= 6'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 6'h01;
        end
    end

    // Phase step: acceleration only for the phases that allow it
    always_comb begin
        ph_step = STEP_NORMAL;
        if (test_reg) begin
            unique case (state_reg)
                ST_PREHEAT: ph_step = STEP_PREHEAT; // [RULE14]
                ST_IGNITE:  ph_step = STEP_IGN;     // [RULE14]
                ST_PRE_RUN: ph_step = STEP_PRE_RUN; // [RULE15]
                default:    ph_step = STEP_NORMAL;
            endcase
        end
    end

    // Ignition minimum threshold doubles in test mode to match the doubled step, so test mode cannot shorten it
    assign ign_fail = (ph_cnt_reg >= IGN_TIMEOUT_T) && !sense.lamp_ignited;
    always_comb begin
        ph_done = 1'b0;
        unique case (state_reg)
            ST_LAMP_WAIT: ph_done = ph_cnt_reg >= START_DELAY_T; // [RULE6]
            ST_PREHEAT:   ph_done = ph_cnt_reg >= PREHEAT_T;
            ST_IGNITE:    ph_done = sense.lamp_ignited &&
                                    (ph_cnt_reg >= (test_reg ? 2 * IGN_MIN_T : IGN_MIN_T)); // [RULE16]
            ST_PRE_RUN:   ph_done = ph_cnt_reg >= PRE_RUN_T;
            ST_FAULT_DLY: ph_done = ph_cnt_reg >= FAULT_DELAY_T; // [RULE2]
            ST_HOLD:      ph_done = off_cnt_reg >= FIRST_RESTART_T; // [RULE7]
            default:      ph_done = 1'b0;
        endcase
    end

    assign fil_fault    = active && (fil_cnt_reg >= FIL_FAULT_T); // [RULE1]
    assign shoot        = active && sense.low_side_current_sense_shoot; // [RULE12]
    assign eol_ac_fault = (state_reg == ST_RUN) && lvs_en_reg && (eol_ac_cnt_reg >= EOL_AC_T); // [RULE17] [RULE19]
    assign eol_dc_fault = (state_reg == ST_RUN) && lvs_en_reg && (eol_dc_cnt_reg >= EOL_DC_T); // [RULE18] [RULE19]
    assign cap_load     = (state_reg == ST_RUN) && sense.hb_period && !pos_seen_reg && !sense.low_side_current_sense_pos; // [RULE11]
    assign dt_miss      = active && sense.hb_period && !dt_seen_reg;
    assign any_fault    = fil_fault || shoot || eol_ac_fault || eol_dc_fault ||
                          (active && sense.prot_fault) ||
                          ((state_reg == ST_IGNITE) && ign_fail);

    always_ff @(posedge clock) begin
        if (core_rst) begin
            state_reg <= ST_LAMP_WAIT;
        end else if (any_fault) begin
            state_reg <= fil_fault ? ST_FAULT_DLY : ST_HOLD; // [RULE1] [RULE7]
        end else begin
            unique case (state_reg)
                ST_LAMP_WAIT: if (ph_done) begin
                    // Short off time resumes without preheating
                    state_reg <= (off_cnt_reg <= FIRST_RESTART_T) ? ST_IGNITE : ST_PREHEAT; // [RULE20]
                end
                ST_PREHEAT: if (ph_done) begin
                    state_reg <= ST_IGNITE;
                end
                ST_IGNITE: if (ph_done) begin
                    state_reg <= ST_PRE_RUN;
                end
                ST_PRE_RUN: if (ph_done) begin
                    state_reg <= ST_RUN;
                end
                ST_RUN: state_reg <= ST_RUN;
                ST_FAULT_DLY: if (ph_done) begin
                    state_reg <= (fault_cnt_reg > FAULT_LIMIT) ? ST_REMOVAL : ST_HOLD; // [RULE2] [RULE3]
                end
                ST_REMOVAL: if (removed_reg && sense.fil_detect_ok) begin
                    state_reg <= ST_HOLD; // [RULE4]
                end
                ST_HOLD: if (ph_done) begin
                    state_reg <= ST_LAMP_WAIT;
                end
            endcase
        end
    end

    // Phase timer restarts on each state change; start delay needs continuous detection
    always_ff @(posedge clock) begin
        if (core_rst || any_fault || ph_done || (state_reg == ST_REMOVAL)) begin
            ph_cnt_reg <= 32'h0000_0000;
        end else if ((state_reg == ST_LAMP_WAIT) &&
                     (!sense.fil_detect_ok || (lvs_en_reg && sense.lvs_grounded))) begin
            ph_cnt_reg <= 32'h0000_0000; // [RULE6] [RULE8]
        end else if (tick) begin
            ph_cnt_reg <= bump(ph_cnt_reg, ph_step);
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst || !sense.fil_above_upper || !active) begin
            fil_cnt_reg <= 32'h0000_0000;
        end else if (tick) begin
            fil_cnt_reg <= bump(fil_cnt_reg, STEP_NORMAL); // [RULE1]
        end
    end

    // Removal must be seen unbroken; an early return clears the proof
    always_ff @(posedge clock) begin
        if (core_rst || (state_reg != ST_REMOVAL)) begin
            rem_cnt_reg <= 32'h0000_0000;
            removed_reg <= 1'b0;
        end else if (sense.fil_above_upper) begin
            if (tick) begin
                rem_cnt_reg <= bump(rem_cnt_reg, STEP_NORMAL);
            end
            if (rem_cnt_reg >= REMOVAL_T) begin
                removed_reg <= 1'b1; // [RULE3]
            end
        end else if (!removed_reg) begin
            rem_cnt_reg <= 32'h0000_0000; // [RULE4]
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            fault_cnt_reg <= 3'h0;
            win_cnt_reg   <= 32'h0000_0000;
        end else if (fil_fault) begin
            fault_cnt_reg <= (fault_cnt_reg == 3'h7) ? fault_cnt_reg : fault_cnt_reg + 3'h1; // [RULE2]
            win_cnt_reg   <= 32'h0000_0000;
        end else if (fault_cnt_reg != 3'h0) begin
            if (win_cnt_reg >= COUNT_WINDOW_T) begin
                fault_cnt_reg <= 3'h0; // [RULE22]
                win_cnt_reg   <= 32'h0000_0000;
            end else if (tick) begin
                win_cnt_reg <= bump(win_cnt_reg, STEP_NORMAL);
            end
        end
    end

    // Off time runs from shutdown until the next start
    always_ff @(posedge clock) begin
        if (core_rst || active) begin
            off_cnt_reg <= 32'h0000_0000;
        end else if (tick) begin
            off_cnt_reg <= bump(off_cnt_reg, STEP_NORMAL);
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst || (state_reg != ST_RUN) || !sense.eol_ac_over) begin
            eol_ac_cnt_reg <= 32'h0000_0000;
        end else if (tick) begin
            eol_ac_cnt_reg <= bump(eol_ac_cnt_reg, STEP_NORMAL); // [RULE17]
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst || (state_reg != ST_RUN) || !sense.eol_dc_over) begin
            eol_dc_cnt_reg <= 32'h0000_0000;
        end else if (tick) begin
            eol_dc_cnt_reg <= bump(eol_dc_cnt_reg, test_reg ? STEP_EOL_DC : STEP_NORMAL); // [RULE18]
        end
    end

    // Lamp-voltage functions follow the pin: ground disables, 1 us at enable level restores
    always_ff @(posedge clock) begin
        if (core_rst) begin
            lvs_en_reg  <= 1'b1;
            lvs_cnt_reg <= 6'h00;
        end else if (sense.lvs_grounded) begin
            lvs_en_reg  <= 1'b0; // [RULE9]
            lvs_cnt_reg <= 6'h00;
        end else if (!lvs_en_reg && sense.lvs_enable_level) begin
            lvs_cnt_reg <= lvs_cnt_reg + 6'h01;
            if (lvs_cnt_reg >= 6'(LVS_ENABLE_CYCLES - 1)) begin
                lvs_en_reg <= 1'b1; // [RULE9]
            end
        end else begin
            lvs_cnt_reg <= 6'h00;
        end
    end

    // Per-period crossing trackers for deadtime and capacitive-load checks
    always_ff @(posedge clock) begin
        if (core_rst || sense.hb_period) begin
            pos_seen_reg <= 1'b0;
            dt_seen_reg  <= 1'b0;
            dt_cnt_reg   <= 8'h00;
        end else begin
            if (sense.low_side_current_sense_pos) begin
                pos_seen_reg <= 1'b1;
            end
            if (!sense.low_side_current_sense_neg) begin
                dt_cnt_reg <= 8'h00;
            end else if (dt_cnt_reg < 8'(DT_MIN_CYCLES)) begin
                dt_cnt_reg <= dt_cnt_reg + 8'h01;
            end else begin
                dt_seen_reg <= 1'b1; // [RULE10]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            dt_ok_reg <= 1'b0;
        end else if (sense.hb_period) begin
            dt_ok_reg <= dt_seen_reg; // [RULE10]
        end
    end

    assign drive.inverter_en = active;
    assign drive.pfc_en      = active;
    assign drive.preheat     = (state_reg == ST_PREHEAT);
    assign drive.lvs_active  = lvs_en_reg; // [RULE8]
    assign drive.deadtime_ok = dt_ok_reg;

    // APB slave: zero wait states, read data captured in the setup cycle
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_setup  = psel && !penable && !pwrite;
    assign pslverr   = psel && penable && (paddr != ADDR_CTRL) && (paddr != ADDR_STATUS) &&
                       (paddr != ADDR_FLAGS);

    always_ff @(posedge clock) begin
        if (core_rst) begin
            test_reg <= CTRL_RESET[CTRL_TEST_BIT]; // [RULE13]
        end else if (wr_access && (paddr == ADDR_CTRL)) begin
            test_reg <= pwdata[CTRL_TEST_BIT];
        end
    end

    // Sticky event flags, write one to clear; a new event wins over the clear
    always_ff @(posedge clock) begin
        if (core_rst) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= (flags_reg & ~((wr_access && (paddr == ADDR_FLAGS)) ? pwdata[5:0] : 6'h00)) |
                         {dt_miss, eol_dc_fault, eol_ac_fault, shoot, cap_load, fil_fault}; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (paddr)
                ADDR_CTRL:   prdata <= {31'h0, test_reg};
                ADDR_STATUS: prdata <= {22'h0, dt_ok_reg, lvs_en_reg, removed_reg,
                                        fault_cnt_reg, state_reg};
                ADDR_FLAGS:  prdata <= {26'h0, flags_reg};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (core_rst);

    sequence s_fil_fault;
        active && fil_fault;
    endsequence
    sequence s_drives_off;
        !drive.inverter_en && !drive.pfc_en && (state_reg == ST_FAULT_DLY);
    endsequence

    property p_fil_shutdown;
        s_fil_fault |=> s_drives_off;
    endproperty
    a_fil_shutdown: assert property (p_fil_shutdown) else $error("Filament fault did not stop drives"); // [RULE1]

    property p_fil_count;
        fil_fault && (fault_cnt_reg < 3'h7) |=> fault_cnt_reg == $past(fault_cnt_reg) + 3'h1;
    endproperty
    a_fil_count: assert property (p_fil_count) else $error("Fault counter did not increment"); // [RULE2]

    property p_removal_branch;
        (state_reg == ST_FAULT_DLY) && ph_done && (fault_cnt_reg > FAULT_LIMIT) |=> state_reg == ST_REMOVAL;
    endproperty
    a_removal_branch: assert property (p_removal_branch) else $error("High count skipped removal wait"); // [RULE3]

    property p_removal_refuse;
        (state_reg == ST_REMOVAL) && !removed_reg |=> state_reg == ST_REMOVAL;
    endproperty
    a_removal_refuse: assert property (p_removal_refuse) else $error("Left removal wait without removal"); // [RULE4]

    property p_hold_min;
        (state_reg == ST_HOLD) && (off_cnt_reg < FIRST_RESTART_T) |=> state_reg == ST_HOLD;
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("Restart before first restart period"); // [RULE7]

    property p_lvs_off;
        sense.lvs_grounded |=> !drive.lvs_active;
    endproperty
    a_lvs_off: assert property (p_lvs_off) else $error("Lamp sense not disabled when grounded"); // [RULE9]

    property p_ign_min;
        (state_reg == ST_IGNITE) ##1 (state_reg == ST_PRE_RUN) |->
            $past(ph_cnt_reg) >= (test_reg ? 2 * IGN_MIN_T : IGN_MIN_T);
    endproperty
    a_ign_min: assert property (p_ign_min) else $error("Ignition shorter than minimum"); // [RULE16]

    property p_cap_flag;
        cap_load |=> flags_reg[1];
    endproperty
    a_cap_flag: assert property (p_cap_flag) else $error("Capacitive load not flagged"); // [RULE11]

    property p_test_clear;
        $rose(uvlo) |=> !test_reg;
    endproperty
    a_test_clear: assert property (@(posedge clock) disable iff (sys_rst) p_test_clear)
        else $error("Lockout left test mode set"); // [RULE13]

    property p_lockout_reset;
        uvlo |=> (fault_cnt_reg == 3'h0) && (state_reg == ST_LAMP_WAIT);
    endproperty
    a_lockout_reset: assert property (@(posedge clock) disable iff (sys_rst) p_lockout_reset)
        else $error("Lockout did not reset counter"); // [RULE21]

endmodule // bfrs_sequencer
`default_nettype wire

// file: logic/bfrs_pkg.sv
// Constants, timing figures and carrier types of the ballast fault and restart sequencer
package bfrs_pkg;
    localparam int unsigned CLK_MHZ          = 50;
    localparam int unsigned US_CYCLES        = CLK_MHZ;          // Cycles per microsecond tick
    // Times in their own unit, tick counts derived (one tick = 1 us)
    localparam int unsigned FIL_FAULT_US     = 700;
    localparam int unsigned FAULT_DELAY_MS   = 200;
    localparam int unsigned REMOVAL_MS       = 100;
    localparam int unsigned START_DELAY_MS   = 100;
    localparam int unsigned COUNT_WINDOW_S   = 40;
    localparam int unsigned IGN_MIN_MS       = 42;
    localparam int unsigned EOL_AC_US        = 620;
    localparam int unsigned EOL_DC_MS        = 2450;
    localparam int unsigned FIRST_RESTART_MS = 1000;
    localparam int unsigned PREHEAT_MS       = 1000;
    localparam int unsigned IGN_TIMEOUT_MS   = 700;
    localparam int unsigned PRE_RUN_MS       = 86;
    localparam int unsigned LVS_ENABLE_US    = 1;
    localparam int unsigned FIL_FAULT_TICKS  = FIL_FAULT_US;
    localparam int unsigned FAULT_DELAY_TICKS = FAULT_DELAY_MS * 1000;
    localparam int unsigned REMOVAL_TICKS    = REMOVAL_MS * 1000;
    localparam int unsigned START_DELAY_TICKS = START_DELAY_MS * 1000;
    localparam int unsigned COUNT_WINDOW_TICKS = COUNT_WINDOW_S * 1000000;
    localparam int unsigned IGN_MIN_TICKS    = IGN_MIN_MS * 1000;
    localparam int unsigned EOL_AC_TICKS     = EOL_AC_US;
    localparam int unsigned EOL_DC_TICKS     = EOL_DC_MS * 1000;
    localparam int unsigned FIRST_RESTART_TICKS = FIRST_RESTART_MS * 1000;
    localparam int unsigned PREHEAT_TICKS    = PREHEAT_MS * 1000;
    localparam int unsigned IGN_TIMEOUT_TICKS = IGN_TIMEOUT_MS * 1000;
    localparam int unsigned PRE_RUN_TICKS    = PRE_RUN_MS * 1000;
    localparam int unsigned LVS_ENABLE_CYCLES = LVS_ENABLE_US * CLK_MHZ;
    localparam int unsigned DT_MIN_CYCLES    = 10;
    // Test-mode acceleration steps and the filament fault-count limit
    localparam logic [6:0] STEP_NORMAL  = 7'h01;
    localparam logic [6:0] STEP_PREHEAT = 7'h04;
    localparam logic [6:0] STEP_IGN     = 7'h02;
    localparam logic [6:0] STEP_PRE_RUN = 7'h0F;
    localparam logic [6:0] STEP_EOL_DC  = 7'h3E;
    localparam logic [2:0] FAULT_LIMIT  = 3'h2;
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_FLAGS  = 12'h008;
    localparam int unsigned CTRL_TEST_BIT = 0;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [5:0]  FLAGS_RESET = 6'h00;

    typedef enum logic [3:0] {
        ST_LAMP_WAIT = 4'h0,
        ST_PREHEAT   = 4'h1,
        ST_IGNITE    = 4'h2,
        ST_PRE_RUN   = 4'h3,
        ST_RUN       = 4'h4,
        ST_FAULT_DLY = 4'h5,
        ST_REMOVAL   = 4'h6,
        ST_HOLD      = 4'h7
    } bfrs_state_t;

    typedef struct packed {
        logic fil_above_upper;   // filament_sense_input above filament_upper_threshold
        logic fil_detect_ok;     // filament_sense_input within valid lamp range
        logic lvs_grounded;      // lamp_voltage_sense_input held at ground
        logic lvs_enable_level;  // lamp_voltage_sense_input at lamp_sense_reenable_level
        logic eol_ac_over;       // Peak-to-peak lamp voltage over its current threshold
        logic eol_dc_over;       // Lamp voltage DC offset over its current threshold
        logic low_side_current_sense_neg;          // low_side_current_sense below -50 mV
        logic low_side_current_sense_pos;          // low_side_current_sense above +50 mV
        logic low_side_current_sense_shoot;        // low_side_current_sense above shoot-through level
        logic hb_period;         // One-cycle pulse at each half-bridge period end
        logic lamp_ignited;
        logic prot_fault;        // Other protection fault that ends in a restart
    } bfrs_sense_t;

    typedef struct packed {
        logic inverter_en;
        logic pfc_en;
        logic preheat;
        logic lvs_active;
        logic deadtime_ok;
    } bfrs_drive_t;
endpackage

// file: tb/bfrs_lamp_model.sv
// Behavioural lamp and half-bridge sense model for the sequencer
`timescale 1ns/1ps
`default_nettype none
module bfrs_lamp_model
    import bfrs_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      lamp_off,
    output var  bfrs_sense_t sense
);
    logic [3:0] phase_reg = 4'h0;
    always_ff @(posedge clock) begin
        phase_reg <= phase_reg + 4'h1;
    end
    always_comb begin
        sense = '0;
        sense.fil_above_upper  = lamp_off;
        sense.fil_detect_ok    = !lamp_off;
        sense.lvs_enable_level = 1'b1;
        // Negative crossing lasts 12 cycles, above the deadtime minimum
        sense.low_side_current_sense_neg         = phase_reg < 4'hC;
        sense.low_side_current_sense_pos         = phase_reg[3];
        sense.hb_period        = phase_reg == 4'hF;
        sense.lamp_ignited     = 1'b1;
    end
endmodule // bfrs_lamp_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the ballast fault and restart sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s exp=%0h got=%0h", nm, ex, got); end end
module tb;
    import bfrs_pkg::*;
    logic        clock = 0, sys_rst = 1, uvlo = 0, lamp_off = 1;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, rv;
    int          failures = 0, samples_checked = 0, n;
    bfrs_sense_t sense;
    bfrs_drive_t drive;
    bfrs_lamp_model i_bfrs_lamp_model (.clock(clock), .lamp_off(lamp_off), .sense(sense));
    // Filament fault time keeps its real tick count; the tick and the fault-delay, removal, start-delay and first-restart waits are shortened
    bfrs_sequencer #(.FAULT_DELAY_T(20), .REMOVAL_T(10), .START_DELAY_T(10), .FIRST_RESTART_T(30),
        .TICK_CYCLES(2)) i_bfrs_sequencer (.clock(clock), .sys_rst(sys_rst), .uvlo(uvlo),
        .sense(sense), .drive(drive), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial forever #10 clock = ~clock;
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clock) penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_inv(input logic v, input int lim);
        n = 0;
        while (drive.inverter_en !== v && n < lim) begin @(posedge clock); n++; end
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin #400000; failures++; summarize(); end
    initial begin
        n = $urandom(32'h8c0c);
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        apb(0, ADDR_CTRL, 0); `CHK("ctrl_rst", CTRL_RESET, rd)
        apb(0, ADDR_STATUS, 0); `CHK("state_rst", 4'h0, rd[3:0])
        `CHK("lvs_on", 1'b1, drive.lvs_active)
        apb(0, 12'h00C, 0); `CHK("unmapped", 1'b1, err)
        for (int k = 1; k <= 3; k++) begin
            lamp_off <= 1'b0;
            wait_inv(1'b1, 600);
            `CHK("start", 1'b1, n >= 18 && n < 600)
            lamp_off <= 1'b1;
            wait_inv(1'b0, 1500);
            `CHK("fault_time", 1'b1, n >= 2 * FIL_FAULT_TICKS - 1 && n <= 2 * FIL_FAULT_TICKS + 4)
            `CHK("pfc_off", 1'b0, drive.pfc_en)
            // Third round shows a lamp back in range with no removal
            lamp_off <= (k < 3);
            apb(0, ADDR_STATUS, 0); `CHK("count", 3'(k), rd[6:4])
            `CHK("fault_st", 4'h5, rd[3:0])
            apb(0, ADDR_FLAGS, 0); `CHK("fil_flag", 1'b1, rd[0])
            apb(1, ADDR_FLAGS, 32'h0000_0001);
            repeat (36) @(posedge clock);
            apb(0, ADDR_STATUS, 0); `CHK("decide", (k > 2) ? 4'h6 : 4'h7, rd[3:0])
            `CHK("held_off", 1'b0, drive.inverter_en)
        end
        lamp_off <= 1'b1;
        repeat ($urandom_range(4, 12)) @(posedge clock);
        lamp_off <= 1'b0;
        repeat (40) @(posedge clock);
        apb(0, ADDR_STATUS, 0); `CHK("refused", 4'h6, rd[3:0])
        lamp_off <= 1'b1;
        repeat ($urandom_range(26, 40)) @(posedge clock);
        lamp_off <= 1'b0;
        wait_inv(1'b1, 600);
        `CHK("removal_start", 1'b1, n < 600)
        `CHK("preheat", 1'b1, drive.preheat)
        `CHK("dt_ok", 1'b1, drive.deadtime_ok)
        rv = $urandom() | 32'h0000_0001;
        apb(1, ADDR_CTRL, rv); apb(0, ADDR_CTRL, 0); `CHK("test_on", 1'b1, rd[0])
        uvlo <= 1'b1; @(posedge clock); uvlo <= 1'b0; @(posedge clock);
        apb(0, ADDR_CTRL, 0); `CHK("test_clr", 1'b0, rd[0])
        apb(0, ADDR_STATUS, 0); `CHK("cnt_clr", 3'h0, rd[6:4])
        summarize();
    end
endmodule // tb
`default_nettype wire
